// File: include/lsr_cfg.svh
// Notes on behaviour
// - self-test runs about five seconds at power-up
// - failed self-test halts start-up, shows error code
// - start mode picks operate or wait-for-enter
// - temporary zero dropped on power loss, set-up
// - calibrated zero writable only in set-up
// - instrument error forces analogue output to zero
// - fixed-output mode ignores measured value
// - two independent supervision channels
// - channels use the faster filtered signal
// - channel states readable over serial link
// - source is raw mV/V or weight
// - signed hysteresis, band above or below
// - relay source in-process, above or below
// - above/below relay follows channel with hysteresis
// - instrument error deactivates both relays
// - serial port serves master or display
// - no slave transmit logic, status leaves on o_level_status
`ifndef LSR_CFG_SVH
`define LSR_CFG_SVH
`define LSR_SELFTEST_MS 5000
`define LSR_CLK_KHZ 125000
`define LSR_SELFTEST_CYC (`LSR_SELFTEST_MS * `LSR_CLK_KHZ)
`define LSR_ZERO_RST 32'h00000000
`define LSR_OUT_ZERO 16'h0000
`endif

// File: include/lsr_pkg.sv
package lsr_pkg;
   typedef enum logic [1:0] {LSR_SRC_INPROC, LSR_SRC_ABOVE, LSR_SRC_BELOW} lsr_relay_src_t;
   typedef struct packed {
      logic src_weight;
      logic signed [31:0] level;
      logic signed [31:0] hyst;
      logic [1:0] relay_src;
   } lsr_chan_cfg_t;
endpackage

// File: core/lsr_channel.sv
`timescale 1ns/1ps
`default_nettype none
`include "lsr_cfg.svh"
module lsr_channel (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // signals
   input wire logic signed [31:0] i_mvv,
   input wire logic signed [31:0] i_weight,
   input wire lsr_pkg::lsr_chan_cfg_t i_cfg,
   output logic o_above
);
   logic signed [32:0] sig;
   logic signed [32:0] lo_edge;
   logic signed [32:0] hi_edge;
   always_comb begin
      sig = i_cfg.src_weight ? 33'(i_weight) : 33'(i_mvv);
      // band spans level..level+hyst, sign chooses side
      if (i_cfg.hyst[31]) begin
         hi_edge = 33'(i_cfg.level);
         lo_edge = 33'(i_cfg.level) + 33'(i_cfg.hyst);
      end else begin
         lo_edge = 33'(i_cfg.level);
         hi_edge = 33'(i_cfg.level) + 33'(i_cfg.hyst);
      end
   end
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_above <= 1'b0;
      end else if (!o_above && sig > hi_edge) begin
         o_above <= 1'b1;
      end else if (o_above && sig < lo_edge) begin
         o_above <= 1'b0;
      end
   end
   above_set_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (sig > hi_edge) |=> o_above) else $error("channel not above");
   above_clr_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (sig < lo_edge) |=> !o_above) else $error("channel not below");
endmodule
`default_nettype wire

// File: core/lsr_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "lsr_cfg.svh"
module lsr_top #(
   parameter longint SELFTEST_CYC = `LSR_SELFTEST_CYC
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // start-up
   input wire logic i_selftest_fail,
   input wire logic [7:0] i_selftest_code,
   input wire logic i_auto_start,
   input wire logic i_enter_key,
   input wire logic i_setup_req,
   input wire logic i_setup_exit,
   input wire logic i_instr_error,
   // zero offsets
   input wire logic i_temp_zero_req,
   input wire logic signed [31:0] i_temp_zero_val,
   input wire logic i_cal_zero_we,
   input wire logic signed [31:0] i_cal_zero_val,
   // measurement, filters
   input wire logic signed [31:0] i_mvv_ana,
   input wire logic signed [31:0] i_mvv_dig,
   input wire logic signed [31:0] i_wt_ana,
   input wire logic signed [31:0] i_wt_dig,
   input wire logic i_ana_bw_higher,
   // analogue output
   input wire logic [15:0] i_ana_code,
   input wire logic i_fixed_mode,
   input wire logic [15:0] i_fixed_code,
   // supervision config
   input wire lsr_pkg::lsr_chan_cfg_t i_cfg1,
   input wire lsr_pkg::lsr_chan_cfg_t i_cfg2,
   // serial use
   input wire logic i_ext_display_mode,
   // outputs
   output logic o_operating,
   output logic o_wait_start,
   output logic o_setup,
   output logic o_error_halt,
   output logic [7:0] o_error_code,
   output logic signed [31:0] o_zero_offset,
   output logic signed [31:0] o_cal_zero,
   output logic [15:0] o_ana_out,
   output logic relay_one_state,
   output logic relay_two_state,
   output logic [1:0] o_level_status,
   output logic o_ext_display_link_flag
);
   // ==========================================================
   // operating state
   typedef enum logic [2:0] {ST_SELFTEST, ST_HALT, ST_WAIT, ST_OPER, ST_SETUP} st_t;
   st_t state;
   logic [39:0] cnt;
   logic enter_s1, enter_s2;
   always_ff @(posedge i_clock) begin
      enter_s1 <= i_enter_key;
      enter_s2 <= enter_s1;
   end
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         state <= ST_SELFTEST;
         cnt <= 40'h0;
         o_error_code <= 8'h00;
      end else begin
         case (state)
            ST_SELFTEST: begin
               if (i_selftest_fail) begin
                  state <= ST_HALT;
                  o_error_code <= i_selftest_code;
               end else if (cnt >= 40'(SELFTEST_CYC - 1)) begin
                  state <= i_auto_start ? ST_OPER : ST_WAIT;
               end else begin
                  cnt <= cnt + 40'h1;
               end
            end
            ST_HALT: state <= ST_HALT;
            ST_WAIT: if (enter_s2) state <= ST_OPER;
            ST_OPER: if (i_setup_req) state <= ST_SETUP;
            ST_SETUP: if (i_setup_exit) state <= ST_OPER;
            default: state <= ST_SELFTEST;
         endcase
      end
   end
   assign o_operating = (state == ST_OPER);
   assign o_wait_start = (state == ST_WAIT);
   assign o_setup = (state == ST_SETUP);
   assign o_error_halt = (state == ST_HALT);
   selftest_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (state == ST_SELFTEST && cnt == 40'h0 && !i_selftest_fail) |=> !o_operating)
      else $error("left self-test early");
   halt_sticky_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      o_error_halt |=> o_error_halt && !o_operating) else $error("halt left");

   // ==========================================================
   // zero offsets
   logic temp_valid;
   logic signed [31:0] temp_zero;
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_cal_zero <= `LSR_ZERO_RST;
      end else if (i_cal_zero_we && state == ST_SETUP) begin
         o_cal_zero <= i_cal_zero_val;
      end
   end
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         temp_valid <= 1'b0;
         temp_zero <= `LSR_ZERO_RST;
      end else if (state == ST_SETUP) begin
         temp_valid <= 1'b0;
      end else if (i_temp_zero_req && state == ST_OPER) begin
         temp_valid <= 1'b1;
         temp_zero <= i_temp_zero_val;
      end
   end
   assign o_zero_offset = temp_valid ? temp_zero : o_cal_zero;
   cal_guard_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (state != ST_SETUP) |=> $stable(o_cal_zero)) else $error("cal zero changed");
   temp_drop_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      o_setup |=> (o_zero_offset == o_cal_zero)) else $error("temp zero kept");

   // ==========================================================
   // analogue output
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) o_ana_out <= `LSR_OUT_ZERO;
      else if (i_instr_error || o_error_halt) o_ana_out <= `LSR_OUT_ZERO;
      else if (i_fixed_mode) o_ana_out <= i_fixed_code;
      else o_ana_out <= i_ana_code;
   end
   ana_zero_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_instr_error |=> o_ana_out == `LSR_OUT_ZERO) else $error("output not zero");

   // ==========================================================
   // supervision and relays
   logic signed [31:0] mvv_f, wt_f;
   logic [1:0] above;
   assign mvv_f = i_ana_bw_higher ? i_mvv_ana : i_mvv_dig;
   assign wt_f = i_ana_bw_higher ? i_wt_ana : i_wt_dig;
   lsr_channel u_ch1 (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_mvv(mvv_f),
      .i_weight(wt_f), .i_cfg(i_cfg1), .o_above(above[0]));
   lsr_channel u_ch2 (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_mvv(mvv_f),
      .i_weight(wt_f), .i_cfg(i_cfg2), .o_above(above[1]));

   function automatic logic relay_fn(input logic [1:0] src, input logic ab, input logic op);
      case (src)
         lsr_pkg::LSR_SRC_INPROC: relay_fn = op;
         lsr_pkg::LSR_SRC_ABOVE: relay_fn = ab;
         lsr_pkg::LSR_SRC_BELOW: relay_fn = !ab;
         default: relay_fn = 1'b0;
      endcase
   endfunction

   always_ff @(posedge i_clock) begin
      if (!i_rst_n || i_instr_error || o_error_halt) begin
         relay_one_state <= 1'b0;
         relay_two_state <= 1'b0;
      end else begin
         relay_one_state <= relay_fn(i_cfg1.relay_src, above[0], o_operating);
         relay_two_state <= relay_fn(i_cfg2.relay_src, above[1], o_operating);
      end
   end
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) o_level_status <= 2'h0;
      else o_level_status <= above;
   end
   // status is only presented here on o_level_status; this module holds no serial reply logic
   always_comb begin
      if (o_ext_display_link_flag) begin
         // display use: no polled replies are expected on the link
      end
   end
   assign o_ext_display_link_flag = i_ext_display_mode;
   relay_err_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_instr_error |=> !relay_one_state && !relay_two_state) else $error("relay on");
   inproc_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (i_cfg1.relay_src == 2'h0 && !i_instr_error && !o_error_halt) |=>
      relay_one_state == $past(o_operating)) else $error("in-process relay");
endmodule
`default_nettype wire

// File: dv/lsr_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module lsr_master_model (
   // clock and poll
   input wire logic i_clock,
   input wire logic i_poll,
   // slave status
   input wire logic [1:0] i_status,
   output logic [1:0] o_reply
);
   // the master opens every exchange, the slave answers only when polled
   always_ff @(posedge i_clock) begin
      if (i_poll) begin
         o_reply <= i_status;
      end
   end
endmodule
`default_nettype wire

// File: dv/tb_lsr_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_lsr_top;
   logic clk = 0, rst_n = 0, fail = 0, auto = 0, enter = 0, sreq = 0, sexit = 0, err = 0;
   logic tz_req = 0, cz_we = 0, bw = 0, fixm = 0, ext_display_link_flag = 0, op, ws, su, halt, r1, r2, extf;
   logic [7:0] code = 8'h5A, ecode;
   logic signed [31:0] tz_val = 0, cz_val = 0, ma = 0, md = 0, wa = 0, wd = 0, zoff, czero;
   logic [15:0] acode = 0, fcode = 0, aout;
   logic [1:0] lst, reply;
   lsr_pkg::lsr_chan_cfg_t c1 = '{1'b1, 32'sh64, 32'sh14, 2'h0};
   lsr_pkg::lsr_chan_cfg_t c2 = '{1'b0, -32'sh32, -32'shA, 2'h0};
   int error_cnt = 0, total_checks = 0, v1, v2;
   logic s1 = 0, s2 = 1;
   logic [31:0] seed = 32'hF983A79F;
   initial begin
      forever #4 clk = ~clk;
   end
   lsr_top #(.SELFTEST_CYC(20)) u_lsr_top (.i_clock(clk), .i_rst_n(rst_n),
      .i_selftest_fail(fail), .i_selftest_code(code), .i_auto_start(auto), .i_enter_key(enter),
      .i_setup_req(sreq), .i_setup_exit(sexit), .i_instr_error(err), .i_temp_zero_req(tz_req),
      .i_temp_zero_val(tz_val), .i_cal_zero_we(cz_we), .i_cal_zero_val(cz_val), .i_mvv_ana(ma),
      .i_mvv_dig(md), .i_wt_ana(wa), .i_wt_dig(wd), .i_ana_bw_higher(bw), .i_ana_code(acode),
      .i_fixed_mode(fixm), .i_fixed_code(fcode), .i_cfg1(c1), .i_cfg2(c2),
      .i_ext_display_mode(ext_display_link_flag), .o_operating(op), .o_wait_start(ws), .o_setup(su),
      .o_error_halt(halt), .o_error_code(ecode), .o_zero_offset(zoff), .o_cal_zero(czero),
      .o_ana_out(aout), .relay_one_state(r1), .relay_two_state(r2), .o_level_status(lst),
      .o_ext_display_link_flag(extf));
   lsr_master_model u_lsr_master_model (.i_clock(clk), .i_poll(1'b1), .i_status(lst),
      .o_reply(reply));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // hysteresis model: set above the upper edge, clear below the lower edge
   function automatic logic upd(input logic s, input int v, input int lo, input int hi);
      return (v > hi) ? 1'b1 : ((v < lo) ? 1'b0 : s);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task automatic go(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic do_reset(input logic f, input logic a);
      @(posedge clk);
      rst_n <= 0;
      fail <= f;
      auto <= a;
      go(4);
      rst_n <= 1;
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge clk);
      error_cnt++;
      stop_test();
   end
   initial begin
      do_reset(0, 0);
      go(10);
      chk({op, ws}, 0);
      go(20);
      chk({op, ws}, 1);
      enter <= 1;
      go(6);
      enter <= 0;
      go(6);
      chk({op, r1, r2}, 7);
      c1.relay_src <= 2'h1;
      c2.relay_src <= 2'h2;
      for (int i = 0; i < 40; i++) begin
         seed = lfsr(seed);
         v1 = 60 + int'(seed[6:0]) % 100;
         v2 = -100 + int'(seed[14:8]) % 100;
         @(posedge clk);
         bw <= seed[16];
         wa <= seed[16] ? v1 : ~v1;
         wd <= seed[16] ? ~v1 : v1;
         ma <= seed[16] ? v2 : ~v2;
         md <= seed[16] ? ~v2 : v2;
         go(5);
         s1 = upd(s1, v1, 100, 120);
         s2 = upd(s2, v2, -60, -50);
         chk(lst, {s2, s1});
         chk(reply, {s2, s1});
         chk({r1, r2}, {s1, !s2});
      end
      acode <= 16'h1234;
      fcode <= 16'hABCD;
      go(5);
      chk(aout, 16'h1234);
      fixm <= 1;
      go(5);
      chk(aout, 16'hABCD);
      err <= 1;
      go(5);
      chk({aout, r1, r2}, 0);
      err <= 0;
      tz_val <= 32'sh5;
      tz_req <= 1;
      cz_val <= 32'sh4D;
      cz_we <= 1;
      go(1);
      tz_req <= 0;
      cz_we <= 0;
      go(5);
      chk({zoff, czero}, {32'h5, 32'h0});
      sreq <= 1;
      go(1);
      sreq <= 0;
      go(5);
      chk({su, zoff}, {1'b1, 32'h0});
      cz_we <= 1;
      go(1);
      cz_we <= 0;
      sexit <= 1;
      ext_display_link_flag <= 1;
      go(1);
      sexit <= 0;
      go(5);
      chk({op, zoff, czero, extf}, {1'b1, 32'h4D, 32'h4D, 1'b1});
      do_reset(1, 0);
      go(40);
      chk({halt, ecode, op, r1, r2}, {1'b1, 8'h5A, 3'h0});
      do_reset(0, 1);
      go(10);
      chk(op, 0);
      go(20);
      chk(op, 1);
      stop_test();
   end
endmodule
`default_nettype wire
